// File: common/lfs_pkg.sv
// lfs_pkg: shared constants and types of the fault supervisor
// assumes a 40 MHz mclk and a 32-bit apb with byte addresses
package lfs_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STAT_OFS     = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_EN_OFS   = 8'h0C;
  localparam logic [7:0] IRQ_CLR_OFS  = 8'h10;
  // control register: bit 0 masks output undervoltage during soft-start
  localparam int          CTRL_MASK_BIT = 0;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0001;
  // status register field positions
  localparam int STAT_LATCH_LSB = 0;   // 3 latched fault bits
  localparam int STAT_UVLO_BIT  = 3;   // filtered input lockout
  localparam int STAT_OPEN_LSB  = 4;   // 4 open-string bits
  localparam int STAT_STATE_LSB = 8;   // 3 state bits
  localparam int STAT_LOWP_BIT  = 11;  // low-power shutdown
  localparam int STAT_FAULT_BIT = 12;  // fault flag active
  // interrupt bits, same layout in status, enable, clear
  localparam int IRQ_LATCH_BIT = 0;    // a latched fault set
  localparam int IRQ_SHDN_BIT  = 1;    // long dim-low shutdown
  localparam int IRQ_UVLO_BIT  = 2;    // input lockout entered
  localparam int IRQ_OPEN_BIT  = 3;    // open string removed
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  // timing
  localparam int MCLK_PERIOD_NS = 25;
  localparam int UVLO_FILT_NS   = 50000;
  localparam int UVLO_FILT_CYC  = (UVLO_FILT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int DIM_LOW_CYC    = 32750;
  // supervisor states
  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_START = 3'b010,
    ST_RUN   = 3'b100
  } lfs_state_type;
endpackage

// File: rtl/lfs_supervisor.sv
// lfs_supervisor: fault supervisor of a four-string boost led driver
// assumes comparator inputs synchronous to mclk, apb master on mclk
module lfs_supervisor #(
  parameter int DIM_LOW_CYCLES = lfs_pkg::DIM_LOW_CYC,
  parameter int DIM_W          = 16
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // comparator indications
  input  wire logic        primary_switch_current_limit,
  input  wire logic        secondary_switch_current_limit,
  input  wire logic        input_sense_trip,
  input  wire logic        switch_node_overvoltage,
  input  wire logic [3:0]  led_sink_pin_shorted,
  input  wire logic [3:0]  led_sink_pin_unregulated,
  input  wire logic [3:0]  led_sink_pin_overvoltage,
  input  wire logic        current_set_pin_overcurrent,
  input  wire logic        frequency_set_pin_overcurrent,
  input  wire logic        output_overvoltage,
  input  wire logic        output_undervoltage,
  input  wire logic        over_temperature,
  input  wire logic        input_lockout_below,
  // dimming and soft-start
  input  wire logic        dim_in,
  input  wire logic        soft_start_done,
  // power stage controls
  output logic             boost_enable,
  output logic             boost_on_time_cut,
  output logic             disconnect_gate_on,
  output logic [3:0]       led_sink_enable,
  output logic             soft_start_go,
  output logic             raise_output,
  output logic             low_power,
  // status
  output logic             fault_n,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////
  // state of the whole block
  typedef struct packed {
    lfs_pkg::lfs_state_type st;  // supervisor state
    logic [DIM_W-1:0]  dim_cnt;  // dim-low cycle count
    logic [11:0]       uvlo_cnt; // lockout filter count
    logic              uvlo;     // filtered lockout
    logic [2:0]        latch;    // latched faults
    logic [3:0]        open_mask;// strings found open
    logic              hunt;     // raising output to find opens
    logic              mask_en;  // startup masking enable
    logic [3:0]        irq_stat; // sticky events
    logic [3:0]        irq_en;   // event enables
    logic              boost;    // registered outputs below
    logic              cut;
    logic              disc;
    logic [3:0]        sink;
    logic              ss_go;
    logic              raise;
    logic              lowp;
    logic              fault_n;
    logic              irq;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } lfs_reg_type;

  lfs_reg_type q;       // registered state
  lfs_reg_type next_q;  // next state

  localparam logic [11:0] UVLO_LAST = 12'(lfs_pkg::UVLO_FILT_CYC - 1);
  localparam logic [DIM_W-1:0] DIM_LAST = DIM_W'(DIM_LOW_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////
  // per-string keep: not found open, not over its pin limit
  logic [3:0] string_keep;  // string may sink current
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_keep
      assign string_keep[g] = ~q.open_mask[g]
                            & ~led_sink_pin_overvoltage[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [2:0]  latch_set;   // new latched events
    logic        latch_any;   // any latched fault now
    logic        latch_clr;   // clear latched faults
    logic        dim_long;    // dim held low long enough
    logic        in_start;    // soft-start phase
    logic        uvp_eff;     // undervoltage after masking
    logic        on;          // block may run at all
    logic        short_hold;  // startup held by shorted pin
    logic        base;        // boost/sinks allowed
    logic        wr;          // apb write this edge
    logic [3:0]  ev;          // interrupt events
    logic [3:0]  clr;         // interrupt clear bits
    logic [31:0] rd;          // read data mux
    logic        bad;         // unmapped address
    next_q     = q;
    latch_set  = 3'h0;
    latch_any  = 1'b0;
    latch_clr  = 1'b0;
    dim_long   = 1'b0;
    in_start   = 1'b0;
    uvp_eff    = 1'b0;
    on         = 1'b0;
    short_hold = 1'b0;
    base       = 1'b0;
    wr         = 1'b0;
    ev         = 4'h0;
    clr        = 4'h0;
    rd         = 32'h0000_0000;
    bad        = 1'b0;

    // lockout filter: act only after the full filter time
    if (input_lockout_below) begin
      if (q.uvlo_cnt != UVLO_LAST) begin
        next_q.uvlo_cnt = q.uvlo_cnt + 12'h001;
      end else begin
        next_q.uvlo = 1'b1;
      end
    end else begin
      next_q.uvlo_cnt = 12'h000;
      next_q.uvlo     = 1'b0;
    end
    if (next_q.uvlo && !q.uvlo) begin
      ev[lfs_pkg::IRQ_UVLO_BIT] = 1'b1;
    end

    // dim-low counter, saturating at the shutdown count
    if (dim_in) begin
      next_q.dim_cnt = '0;
    end else if (q.dim_cnt != DIM_LAST) begin
      next_q.dim_cnt = q.dim_cnt + DIM_W'(1);
    end else if (q.st != lfs_pkg::ST_OFF) begin
      dim_long = 1'b1;
    end

    // latched faults: set wins over clear
    if (q.st != lfs_pkg::ST_OFF && !q.uvlo) begin
      latch_set = {switch_node_overvoltage,
                   input_sense_trip,
                   secondary_switch_current_limit};
    end
    latch_clr = q.uvlo || dim_long;
    next_q.latch = (latch_clr ? 3'h0 : q.latch) | latch_set;
    latch_any = |q.latch || |latch_set;
    if (|(latch_set & ~q.latch)) begin
      ev[lfs_pkg::IRQ_LATCH_BIT] = 1'b1;
    end

    // supervisor state machine
    unique case (q.st)
      lfs_pkg::ST_OFF: begin
        // wait for dim high before re-enabling
        if (dim_in && !q.uvlo) begin
          next_q.st   = lfs_pkg::ST_START;
          next_q.lowp = 1'b0;
        end
      end
      lfs_pkg::ST_START: begin
        // leave soft-start when done and no short seen
        if (soft_start_done && !(|led_sink_pin_shorted)
            && !frequency_set_pin_overcurrent) begin
          next_q.st = lfs_pkg::ST_RUN;
        end
      end
      lfs_pkg::ST_RUN: begin
        // frequency-set fault restarts through soft-start
        if (frequency_set_pin_overcurrent) begin
          next_q.st = lfs_pkg::ST_START;
        end
      end
    endcase
    // long dim-low or lockout forces shutdown
    if (dim_long || q.uvlo) begin
      next_q.st        = lfs_pkg::ST_OFF;
      next_q.open_mask = 4'h0;
      next_q.hunt      = 1'b0;
    end
    if (dim_long) begin
      next_q.lowp = 1'b1;
      ev[lfs_pkg::IRQ_SHDN_BIT] = 1'b1;
    end

    // open-pin search: raise output until overvoltage
    if (q.st == lfs_pkg::ST_RUN && !dim_long && !q.uvlo) begin
      if (!q.hunt && |(led_sink_pin_unregulated & ~q.open_mask)) begin
        next_q.hunt = 1'b1;
      end else if (q.hunt && output_overvoltage) begin
        next_q.open_mask = q.open_mask | led_sink_pin_unregulated;
        next_q.hunt      = 1'b0;
        ev[lfs_pkg::IRQ_OPEN_BIT] = 1'b1;
      end
    end

    // output decisions
    in_start = (q.st == lfs_pkg::ST_START);
    uvp_eff  = output_undervoltage && (q.st != lfs_pkg::ST_OFF)
             && !(in_start && q.mask_en);
    on = (q.st != lfs_pkg::ST_OFF) && !q.uvlo
       && !over_temperature
       && !latch_any && !dim_long
       && !frequency_set_pin_overcurrent;
    short_hold = in_start && |led_sink_pin_shorted;
    base = on && !current_set_pin_overcurrent
         && !uvp_eff && !short_hold;
    next_q.boost = base && !output_overvoltage;
    next_q.cut   = base && !output_overvoltage
                 && primary_switch_current_limit;
    next_q.disc  = on;
    next_q.sink  = base ? string_keep : 4'h0;
    next_q.ss_go = in_start && base;
    next_q.raise = next_q.hunt;
    next_q.fault_n = !(latch_any
                     || frequency_set_pin_overcurrent
                        && q.st != lfs_pkg::ST_OFF
                     || uvp_eff);

    // apb: answer on the access cycle after setup
    wr = psel && penable && pwrite && q.pready;
    if (wr && !q.pslverr) begin
      unique case (paddr)
        lfs_pkg::CTRL_OFS: begin
          next_q.mask_en = pwdata[lfs_pkg::CTRL_MASK_BIT];
        end
        lfs_pkg::IRQ_EN_OFS: begin
          next_q.irq_en = pwdata[3:0];
        end
        lfs_pkg::IRQ_CLR_OFS: begin
          clr = pwdata[3:0];
        end
        default: begin
          clr = 4'h0;  // read-only registers ignore writes
        end
      endcase
    end
    // sticky events, set wins over clear
    next_q.irq_stat = (q.irq_stat & ~clr) | ev;
    next_q.irq      = |(next_q.irq_stat & next_q.irq_en);

    // read mux sampled in the setup cycle
    unique case (paddr)
      lfs_pkg::CTRL_OFS: begin
        rd[lfs_pkg::CTRL_MASK_BIT] = q.mask_en;
      end
      lfs_pkg::STAT_OFS: begin
        rd[lfs_pkg::STAT_LATCH_LSB +: 3] = q.latch;
        rd[lfs_pkg::STAT_UVLO_BIT]       = q.uvlo;
        rd[lfs_pkg::STAT_OPEN_LSB +: 4]  = q.open_mask;
        rd[lfs_pkg::STAT_STATE_LSB +: 3] = q.st;
        rd[lfs_pkg::STAT_LOWP_BIT]       = q.lowp;
        rd[lfs_pkg::STAT_FAULT_BIT]      = !q.fault_n;
      end
      lfs_pkg::IRQ_STAT_OFS: begin
        rd[3:0] = q.irq_stat;
      end
      lfs_pkg::IRQ_EN_OFS: begin
        rd[3:0] = q.irq_en;
      end
      lfs_pkg::IRQ_CLR_OFS: begin
        rd = 32'h0000_0000;  // write-only
      end
      default: begin
        bad = 1'b1;  // unmapped: error answer
      end
    endcase
    if (psel && !penable) begin
      next_q.pready  = 1'b1;
      next_q.pslverr = bad;
      next_q.prdata  = pwrite ? 32'h0000_0000 : rd;
    end else begin
      next_q.pready  = 1'b0;
      next_q.pslverr = 1'b0;
      next_q.prdata  = 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register, synchronous active-low reset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      q           <= '0;
      q.st        <= lfs_pkg::ST_OFF;
      q.mask_en   <= lfs_pkg::CTRL_RST[lfs_pkg::CTRL_MASK_BIT];
      q.irq_en    <= lfs_pkg::IRQ_EN_RST;
      q.fault_n   <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign prdata             = q.prdata;
  assign pready             = q.pready;
  assign pslverr            = q.pslverr;
  assign boost_enable       = q.boost;
  assign boost_on_time_cut  = q.cut;
  assign disconnect_gate_on = q.disc;
  assign led_sink_enable    = q.sink;
  assign soft_start_go      = q.ss_go;
  assign raise_output       = q.raise;
  assign low_power          = q.lowp;
  assign fault_n            = q.fault_n;
  assign irq                = q.irq;

endmodule

// File: tb/lfs_props.sv
// lfs_props: assertions on the supervisor ports
// assumes one mclk domain, reset_n synchronous active low
module lfs_props #(
  parameter int DIM_LOW_CYCLES = lfs_pkg::DIM_LOW_CYC
) (
  // clock, reset, bus handshake and dim input
  input wire logic       mclk, reset_n, psel, penable, pready, dim_in,
  // fault indications and sink enables
  input wire logic       primary_switch_current_limit, secondary_switch_current_limit,
  input wire logic       input_sense_trip, switch_node_overvoltage, current_set_pin_overcurrent,
  input wire logic       output_overvoltage, output_undervoltage, over_temperature,
  input wire logic [3:0] led_sink_pin_overvoltage, led_sink_enable,
  // power stage controls and flag
  input wire logic       boost_enable, boost_on_time_cut, disconnect_gate_on, raise_output,
  input wire logic       low_power, fault_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [31:0] low_cnt;  // consecutive low dim samples
  logic        latch_in; // any latching fault present
  assign latch_in = secondary_switch_current_limit | input_sense_trip | switch_node_overvoltage;
  ////////////////////////////////////////////////////////////
  // count low dim samples, saturating
  always_ff @(posedge mclk) begin
    if (!reset_n || dim_in) begin
      low_cnt <= '0;
    end else if (low_cnt != 32'hFFFF) begin
      low_cnt <= low_cnt + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  latch_off_a: assert property (latch_in && disconnect_gate_on |=>
    !boost_enable && !disconnect_gate_on && led_sink_enable == 4'h0 && !fault_n) else $error("latch left on");
  cycle_cut_a: assert property (primary_switch_current_limit && boost_enable |=>
    boost_on_time_cut && disconnect_gate_on && fault_n) else $error("no on-time cut");
  ovp_halt_a: assert property (output_overvoltage |=> !boost_enable) else $error("boost ran in ovp");
  current_set_pin_off_a: assert property (current_set_pin_overcurrent |=>
    !boost_enable && led_sink_enable == 4'h0) else $error("current_set_pin fault ignored");
  uvp_flag_a: assert property (output_undervoltage && led_sink_enable != 4'h0 |=>
    !fault_n && disconnect_gate_on && led_sink_enable == 4'h0) else $error("uvp not flagged");
  otp_off_a: assert property (over_temperature |=>
    !boost_enable && !disconnect_gate_on && led_sink_enable == 4'h0) else $error("otp left on");
  pin_ov_a: assert property (1'b1 |=>
    (led_sink_enable & $past(led_sink_pin_overvoltage)) == 4'h0) else $error("pin ov string on");
  shutdown_a: assert property (low_cnt >= DIM_LOW_CYCLES + 2 |-> low_power) else $error("no shutdown");
  bus_answer_a: assert property (psel && !penable |=> pready ##1 !pready) else $error("pready timing");
  c_flag: cover property (!fault_n);
  c_lowp: cover property ($rose(low_power));
  c_raise: cover property ($fell(raise_output));
endmodule
bind lfs_supervisor lfs_props #(.DIM_LOW_CYCLES(DIM_LOW_CYCLES)) u_props (
  .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready), .dim_in(dim_in),
  .primary_switch_current_limit(primary_switch_current_limit),
  .secondary_switch_current_limit(secondary_switch_current_limit), .input_sense_trip(input_sense_trip),
  .switch_node_overvoltage(switch_node_overvoltage), .current_set_pin_overcurrent(current_set_pin_overcurrent),
  .output_overvoltage(output_overvoltage), .output_undervoltage(output_undervoltage),
  .over_temperature(over_temperature), .led_sink_pin_overvoltage(led_sink_pin_overvoltage),
  .led_sink_enable(led_sink_enable), .boost_enable(boost_enable), .boost_on_time_cut(boost_on_time_cut),
  .disconnect_gate_on(disconnect_gate_on), .raise_output(raise_output), .low_power(low_power), .fault_n(fault_n));

// File: tb/lfs_stage_model.sv
// lfs_stage_model: boost stage and led strings beside the supervisor
// assumes mclk domain; ramps are coarse cycle counts
module lfs_stage_model (
  // clock, reset, supervisor controls and bench overvoltage request
  input  wire logic mclk, reset_n, soft_start_go, raise_output, ovp_req,
  // stage indications
  output logic      soft_start_done, output_overvoltage
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ss_cnt; // soft-start ramp progress
  logic [3:0] up_cnt; // output rise while searching
  ////////////////////////////////////////////////////////////
  // ramp soft-start and the output while asked to
  always_ff @(posedge mclk) begin
    if (!reset_n || !soft_start_go) begin
      ss_cnt <= 4'h0;
    end else if (ss_cnt != 4'h8) begin
      ss_cnt <= ss_cnt + 4'h1;
    end
    if (!reset_n || !raise_output) begin
      up_cnt <= 4'h0;
    end else if (up_cnt != 4'h6) begin
      up_cnt <= up_cnt + 4'h1;
    end
  end
  assign soft_start_done    = ss_cnt == 4'h8;
  assign output_overvoltage = ovp_req | (up_cnt == 4'h6);
endmodule

// File: tb/led_driver_fault_supervisor_bench.sv
// led_driver_fault_supervisor_bench: directed tests of the supervisor
// assumes lfs_pkg, the checker and the stage model are compiled first
module led_driver_fault_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIM = 40; // short dim-low count
  logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        prim, sec, isns, swov, current_set_pin, frequency_set_pin, ovp_req, ovp, uvp, otp, lock, dim_in, ssd;
  logic [3:0]  shrt, unreg, pinov, sinks;
  logic        boost, cut, disc, ssgo, raise, lowp, fault_n, irq;
  int          errors, cmp_count;
  lfs_supervisor #(.DIM_LOW_CYCLES(DIM)) uut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .primary_switch_current_limit(prim), .secondary_switch_current_limit(sec), .input_sense_trip(isns),
    .switch_node_overvoltage(swov), .led_sink_pin_shorted(shrt), .led_sink_pin_unregulated(unreg),
    .led_sink_pin_overvoltage(pinov), .current_set_pin_overcurrent(current_set_pin), .frequency_set_pin_overcurrent(frequency_set_pin),
    .output_overvoltage(ovp), .output_undervoltage(uvp), .over_temperature(otp), .input_lockout_below(lock),
    .dim_in(dim_in), .soft_start_done(ssd), .boost_enable(boost), .boost_on_time_cut(cut),
    .disconnect_gate_on(disc), .led_sink_enable(sinks), .soft_start_go(ssgo), .raise_output(raise),
    .low_power(lowp), .fault_n(fault_n), .irq(irq));
  lfs_stage_model stage (.mclk(mclk), .reset_n(reset_n), .soft_start_go(ssgo), .raise_output(raise),
    .ovp_req(ovp_req), .soft_start_done(ssd), .output_overvoltage(ovp));
  ////////////////////////////////////////////////////////////
  // compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // wait n edges, then look at settled outputs
  task look(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  // wait for a sink pattern with soft-start over, bounded
  task wait_sinks(input logic [3:0] v);
    for (int n = 0; n < 400 && (sinks !== v || ssgo !== 1'b0); n++) @(negedge mclk);
    chk("sinks", {ssgo, sinks}, {1'b0, v});
  endtask
  // one apb transfer, waits for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    chk("apb ready", pready, 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  ////////////////////////////////////////////////////////////
  task t_regs();
    apb(1'b0, lfs_pkg::CTRL_OFS, 32'h0);
    chk("ctrl", rd, lfs_pkg::CTRL_RST);
    apb(1'b0, lfs_pkg::IRQ_EN_OFS, 32'h0);
    chk("irq_en", rd, 32'h0);
    apb(1'b1, lfs_pkg::IRQ_EN_OFS, 32'h1);
    apb(1'b0, lfs_pkg::IRQ_EN_OFS, 32'h0);
    chk("irq_en set", rd, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    $display("done regs");
  endtask
  task t_start();
    wait_sinks(4'hF);
    chk("run", {disc, fault_n, lowp}, 3'b110);
    @(posedge mclk);
    pinov <= 4'h2;
    look(1);
    chk("pin ov", {boost, sinks}, 5'h1D);
    @(posedge mclk);
    pinov <= 4'h0;
    prim <= 1'b1;
    look(1);
    chk("cycle cut", {cut, disc, fault_n, sinks}, 7'h7F);
    @(posedge mclk);
    prim <= 1'b0;
    $display("done start");
  endtask
  task t_auto();
    logic [3:0] exp_t [5];
    exp_t = '{4'h5, 4'h7, 4'h0, 4'h4, 4'h1};
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      {current_set_pin, ovp_req, frequency_set_pin, uvp, otp} <= 5'h10 >> i;
      look(1);
      chk("auto", {boost, disc, |sinks, fault_n}, exp_t[i]);
      @(posedge mclk);
      {current_set_pin, ovp_req, frequency_set_pin, uvp, otp} <= 5'h00;
      wait_sinks(4'hF);
    end
    $display("done auto");
  endtask
  task t_latch();
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      {sec, isns, swov} <= 3'h4 >> i;
      look(1);
      chk("latch", {boost, disc, sinks, fault_n, irq}, 8'h01);
      @(posedge mclk);
      {sec, isns, swov} <= 3'h0;
      apb(1'b0, lfs_pkg::IRQ_STAT_OFS, 32'h0);
      chk("irq stat", rd[0], 1'b1);
      apb(1'b1, lfs_pkg::IRQ_CLR_OFS, 32'h1);
      // one low sample short of the shutdown count
      dim_in <= 1'b0;
      look(DIM - 2);
      @(posedge mclk);
      dim_in <= 1'b1;
      look(3);
      chk("held", {fault_n, irq}, 2'b00);
      @(posedge mclk);
      dim_in <= 1'b0;
      look(DIM + 1);
      chk("shutdown", {lowp, fault_n, sinks}, 6'h30);
      @(posedge mclk);
      dim_in <= 1'b1;
      wait_sinks(4'hF);
    end
    $display("done latch");
  endtask
  task t_open();
    @(posedge mclk);
    unreg <= 4'h4;
    look(1);
    chk("raise", raise, 1'b1);
    for (int n = 0; n < 40 && raise !== 1'b0; n++) @(negedge mclk);
    // open mask reaches the sinks one edge after the search ends
    look(1);
    chk("open drop", {raise, fault_n, sinks}, 6'h1B);
    @(posedge mclk);
    unreg <= 4'h0;
    look(3);
    chk("resume", boost, 1'b1);
    $display("done open");
  endtask
  task t_lockout();
    @(posedge mclk);
    lock <= 1'b1;
    look(1000);
    @(posedge mclk);
    lock <= 1'b0;
    look(2);
    chk("glitch", {disc, sinks}, 5'h1B);
    @(posedge mclk);
    sec <= 1'b1;
    look(1);
    @(posedge mclk);
    sec <= 1'b0;
    lock <= 1'b1;
    shrt <= 4'h1;
    look(lfs_pkg::UVLO_FILT_CYC + 3);
    chk("lockout", {boost, disc, |sinks, fault_n}, 4'h1);
    @(posedge mclk);
    lock <= 1'b0;
    look(30);
    chk("short hold", {ssgo, boost, disc, |sinks, fault_n}, 5'h05);
    // undervoltage in soft-start: masked, then unmasked
    @(posedge mclk);
    uvp <= 1'b1;
    look(2);
    chk("uvp masked", fault_n, 1'b1);
    apb(1'b1, lfs_pkg::CTRL_OFS, 32'h0);
    look(2);
    chk("uvp unmasked", {disc, fault_n}, 2'b10);
    @(posedge mclk);
    uvp <= 1'b0;
    shrt <= 4'h0;
    wait_sinks(4'hF);
    chk("flag clear", fault_n, 1'b1);
    $display("done lockout");
  endtask
  ////////////////////////////////////////////////////////////
  // verdict and end of run
  task close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // free-running mclk
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    close_out();
  end
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {prim, sec, isns, swov, current_set_pin, frequency_set_pin, ovp_req, uvp, otp, lock} = '0;
    {shrt, unreg, pinov} = '0;
    dim_in = 1'b1;
    reset_n = 1'b0;
    errors = 0;
    cmp_count = 0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    t_start();
    t_auto();
    t_latch();
    t_open();
    t_lockout();
    close_out();
  end
endmodule
